//--- tb.sv
`timescale 1ns/1ns
`include "ucr_defines.svh"

module tb;
localparam logic [7:0] C1 = `UCR_OFS_CTRL_ONE;
localparam logic [7:0] C2 = `UCR_OFS_CTRL_TWO;
localparam logic [7:0] C3 = `UCR_OFS_CTRL_THREE;
localparam logic [7:0] S1 = `UCR_OFS_STATUS_ONE;
localparam logic [7:0] DT = `UCR_OFS_DATA;
localparam int LIM = 3000;
logic clk_i, rst_i, cyc, stb, we, ack, txp, rxp, tirq, rirq, eirq, inv;
logic [7:0] adr;
logic [3:0] sel, nb;
logic [31:0] dati, dato;
int miscompares, comparisons, n;

ucr_serial_ctrl dut (.clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc),
    .stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(sel), .dat_i(dati),
    .dat_o(dato), .ack_o(ack), .rx_pin_i(rxp), .tx_pin_o(txp),
    .tx_irq_o(tirq), .rx_irq_o(rirq), .err_irq_o(eirq));
ucr_remote_xcvr px (.clk_i(clk_i), .line_i(txp), .inv_i(inv),
    .nbits_i(nb), .line_o(rxp), .word_o(), .stop_o(), .count_o());

initial
begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
end

// ----------------------------------------
// report and bus tasks
// ----------------------------------------
task automatic print_verdict();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
        $display("Run complete: PASS");
    else
        $display("Run complete: FAIL");
    $finish;
endtask : print_verdict

task automatic chk(input string nm, input logic [8:0] e, input logic [8:0] s);
    comparisons++;
    if (s !== e)
    begin
        $display("BAD %s expected %h seen %h", nm, e, s);
        miscompares++;
    end
endtask : chk

task automatic bound(input int k, input string nm);
    if (k >= LIM)
    begin
        $display("BAD %s expected answer seen timeout", nm);
        miscompares++;
        print_verdict();
    end
endtask : bound

task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d,
    output logic [7:0] q);
    int k;
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    dati <= {24'h0, d};
    k = 0;
    do
    begin
        @(posedge clk_i);
        k++;
    end
    while (ack !== 1'b1 && k < LIM);
    bound(k, "ack");
    q = dato[7:0];
    cyc <= 1'b0;
    stb <= 1'b0;
    @(posedge clk_i);
endtask : bus

task automatic wr(input logic [7:0] a, input logic [7:0] d);
    logic [7:0] q;
    bus(a, 1'b1, d, q);
endtask : wr

task automatic rdc(input logic [7:0] a, input logic [7:0] m,
    input logic [7:0] e, input string nm);
    logic [7:0] q;
    bus(a, 1'b0, 8'h00, q);
    chk(nm, {1'b0, e}, {1'b0, q & m});
endtask : rdc

// cycles until the tx line is v
task automatic wait_tx(input logic v, output int k);
    k = 0;
    while (txp !== v && k < LIM)
    begin
        @(posedge clk_i);
        k++;
    end
    bound(k, "tx line");
endtask : wait_tx

task automatic wait_rx(input logic [8:0] e, input string nm);
    int c0, k;
    c0 = px.count_o;
    k = 0;
    while (px.count_o == c0 && k < LIM)
    begin
        @(posedge clk_i);
        k++;
    end
    bound(k, nm);
    chk(nm, e, px.word_o);
endtask : wait_rx

// ----------------------------------------
// main sequence
// ----------------------------------------
initial
begin
    miscompares = 0;
    comparisons = 0;
    rst_i = 1'b1;
    {cyc, stb, we, inv} = 4'h0;
    adr = 8'h00;
    sel = 4'h1;
    dati = 32'h0;
    nb = 4'h8;
    repeat (12) @(posedge clk_i);
    rst_i <= 1'b0;
    @(posedge clk_i);
    rdc(C1, 8'hff, 8'h00, "ctrl_one");
    rdc(C2, 8'hff, 8'h00, "ctrl_two");
    rdc(C3, 8'h0f, 8'h00, "ctrl_three");
    rdc(S1, 8'hff, 8'hc0, "status_one");
    rdc(8'h04, 8'hff, 8'h00, "unmapped");
    wr(C2, 8'h0c);
    rdc(C2, 8'h0c, 8'h00, "enables_refused");
    wr(C1, 8'h20);
    repeat (3) @(posedge clk_i);
    chk("idle_inverted", 9'h000, {8'h0, txp});
    $display("test reset done");
    // baud divisor 0: one bit is 16 clocks
    wr(8'h24, 8'h00);
    wr(C1, 8'h40);
    wr(C2, 8'h0c);
    wr(DT, 8'ha5);
    wait_tx(1'b0, n);
    chk("preamble_ten", 9'h001, {8'h0, n >= 150});
    wait_rx(9'h0a5, "tx_char");
    chk("stop_bit", 9'h001, {8'h0, px.stop_o});
    rdc(S1, 8'h80, 8'h80, "empty");
    wr(C1, 8'h00);
    wr(C1, 8'h50);
    rdc(S1, 8'hc0, 8'hc0, "off_flags");
    nb <= 4'h9;
    wr(C3, 8'h40);
    wr(C2, 8'h0c);
    wr(DT, 8'h3c);
    wait_tx(1'b0, n);
    chk("preamble_eleven", 9'h001, {8'h0, n >= 166});
    wait_rx(9'h13c, "tx_nine");
    nb <= 4'h8;
    wr(C1, 8'h43);
    wr(DT, 8'h03);
    wait_rx(9'h083, "odd_parity");
    wr(C1, 8'h42);
    wr(DT, 8'h03);
    wait_rx(9'h003, "even_parity");
    $display("test transmit done");
    wr(C2, 8'h0d);
    wait_tx(1'b0, n);
    n = 0;
    repeat (480)
    begin
        @(posedge clk_i);
        n = n + (txp !== 1'b0);
    end
    chk("break_run", 9'h000, n[8:0]);
    wr(C2, 8'h0c);
    wait_tx(1'b1, n);
    chk("break_end", 9'h001, {8'h0, n < 200});
    repeat (300) @(posedge clk_i);
    $display("test break done");
    // remote line held low is cut off in loopback
    px.hold(1'b0);
    wr(C1, 8'hc0);
    wr(C2, 8'h2c);
    wr(S1, 8'h3f);
    wr(DT, 8'h5a);
    n = 0;
    while (rirq !== 1'b1 && n < LIM)
    begin
        @(posedge clk_i);
        n++;
    end
    bound(n, "loop_irq");
    rdc(DT, 8'hff, 8'h5a, "loop_data");
    px.hold(1'b1);
    wr(C2, 8'h28);
    rdc(S1, 8'h20, 8'h20, "full_kept");
    $display("test loopback done");
    wr(C1, 8'h50);
    wr(C2, 8'h04);
    wr(S1, 8'h3f);
    px.send_char(9'h1a5, 9, 1'b1);
    repeat (4) @(posedge clk_i);
    rdc(DT, 8'hff, 8'ha5, "rx_nine_data");
    rdc(C3, 8'h80, 8'h80, "rx_ninth");
    wr(C1, 8'h40);
    wr(S1, 8'h3f);
    px.send_char(9'h07f, 8, 1'b1);
    repeat (4) @(posedge clk_i);
    rdc(C3, 8'h80, 8'h00, "rx_ninth_mirror");
    wr(S1, 8'h3f);
    wr(C3, 8'h00);
    px.send_char(9'h011, 8, 1'b0);
    repeat (4) @(posedge clk_i);
    rdc(S1, 8'h02, 8'h02, "frame_fault");
    chk("err_masked", 9'h000, {8'h0, eirq});
    wr(C3, 8'h02);
    repeat (3) @(posedge clk_i);
    chk("err_irq", 9'h001, {8'h0, eirq});
    $display("test receive done");
    wr(S1, 8'h3f);
    wr(C1, 8'h48);
    wr(C2, 8'h26);
    px.send_char(9'h005, 8, 1'b1);
    repeat (4) @(posedge clk_i);
    chk("standby_quiet", 9'h000, {8'h0, rirq});
    rdc(S1, 8'h20, 8'h00, "no_mark");
    px.send_char(9'h085, 8, 1'b1);
    repeat (4) @(posedge clk_i);
    rdc(C2, 8'h02, 8'h00, "woken");
    rdc(S1, 8'h20, 8'h20, "mark_full");
    chk("wake_irq", 9'h001, {8'h0, rirq});
    $display("test wakeup done");
    print_verdict();
end
endmodule : tb

//--- ucr_defines.svh
// Overview of operation
// (R01) loopback feeds transmitter output into receiver
// (R02) software enables both directions for loopback
// (R03) unit enable runs port; off sets tx flags
// (R04) polarity flip inverts every transmitted level
// (R05) one start, one stop; 10/11 bit frames
// (R06) parity occupies character MSB, odd or even
// (R07) software keeps parity type stable mid-character
// (R08) wakeup by address mark or idle line
// (R09) idle counting starts after stop or start
// (R10) enabling transmitter sends an all-ones preamble
// (R11) disabling transmitter finishes current character first
// (R12) re-enable during transfer queues idle character
// (R13) software leaves enables alone while unit off
// (R14) receiver disable keeps receiver flags intact
// (R15) standby suppresses receiver irq, wakeup clears it
// (R16) break release sends break then one mark
// (R17) held break sends breaks back to back
// (R18) software avoids early break after empty flag
// (R19) received ninth bit captured with data buffer
// (R20) ninth tx bit loads with data; unreset
// (R21) four enables gate transmit and receive flags
// (R22) error request gated per error flag
// (R23) mark wakeup sets full; idle wakeup sets nothing
// (R24) buffer-to-shifter transfer and reset set empty
// (R25) preamble length follows selected frame length
`ifndef UCR_DEFINES_SVH
`define UCR_DEFINES_SVH

`define UCR_OFS_CTRL_ONE 8'h10
`define UCR_OFS_CTRL_TWO 8'h14
`define UCR_OFS_CTRL_THREE 8'h18
`define UCR_OFS_STATUS_ONE 8'h1c
`define UCR_OFS_DATA 8'h20
`define UCR_OFS_BAUD 8'h24

// ctrl_one fields
`define UCR_C1_LOOP 7
`define UCR_C1_UNIT 6
`define UCR_C1_POL 5
`define UCR_C1_NINE 4
`define UCR_C1_MARK 3
`define UCR_C1_ICNT 2
`define UCR_C1_PON 1
`define UCR_C1_ODD 0
// ctrl_two fields
`define UCR_C2_TEIE 7
`define UCR_C2_DNIE 6
`define UCR_C2_RFIE 5
`define UCR_C2_IDIE 4
`define UCR_C2_TXON 3
`define UCR_C2_RXON 2
`define UCR_C2_STBY 1
`define UCR_C2_BRK 0
// ctrl_three fields
`define UCR_C3_TX9 6
// status_one fields; low nibble of ctrl_three uses the same error order
`define UCR_S1_EMPTY 7
`define UCR_S1_DONE 6
`define UCR_S1_FULL 5
`define UCR_S1_IDLE 4
`define UCR_S1_OVR 3
`define UCR_S1_NOISE 2
`define UCR_S1_FRAME 1
`define UCR_S1_PAR 0

`define UCR_BAUD_RESET 16'h0043
`define UCR_OVERSAMPLE 4'hf
`define UCR_MID_LO 4'h7
`define UCR_MID_HI 4'h9

`endif

//--- ucr_pkg.sv
package ucr_pkg;

typedef enum logic [1:0] {
    UCR_TX_IDLE,
    UCR_TX_SHIFT
} ucr_tx_state_t;

typedef enum logic [1:0] {
    UCR_RX_IDLE,
    UCR_RX_START,
    UCR_RX_BITS
} ucr_rx_state_t;

endpackage : ucr_pkg

//--- ucr_remote_xcvr.sv
`timescale 1ns/1ns

module ucr_remote_xcvr #(parameter int BIT_CLKS = 16)
(
    input wire logic clk_i,
    input wire logic line_i,
    input wire logic inv_i,
    input wire logic [3:0] nbits_i,
    output logic line_o,
    output logic [8:0] word_o,
    output logic stop_o,
    output int count_o
);
// ----------------------------------------
// sender, lsb first
// ----------------------------------------
task automatic send_char(input logic [8:0] v, input int nb, input logic stp);
    int i;
    line_o <= 1'b0;
    repeat (BIT_CLKS) @(posedge clk_i);
    for (i = 0; i < nb; i++)
    begin
        line_o <= v[i];
        repeat (BIT_CLKS) @(posedge clk_i);
    end
    line_o <= stp;
    repeat (BIT_CLKS) @(posedge clk_i);
    line_o <= 1'b1;
endtask : send_char

task automatic hold(input logic v);
    line_o <= v;
endtask : hold

// ----------------------------------------
// receiver, samples mid-bit
// ----------------------------------------
initial
begin
    int i;
    logic [8:0] w;
    line_o = 1'b1;
    word_o = 9'h000;
    stop_o = 1'b0;
    count_o = 0;
    forever
    begin
        @(posedge clk_i);
        if ((line_i ^ inv_i) === 1'b0)
        begin
            repeat (BIT_CLKS / 2) @(posedge clk_i);
            w = 9'h000;
            for (i = 0; i < nbits_i; i++)
            begin
                repeat (BIT_CLKS) @(posedge clk_i);
                w[i] = line_i ^ inv_i;
            end
            repeat (BIT_CLKS) @(posedge clk_i);
            stop_o <= line_i ^ inv_i;
            word_o <= w;
            count_o <= count_o + 1;
        end
    end
end
endmodule : ucr_remote_xcvr

//--- ucr_serial_ctrl.sv
`timescale 1ns/1ns
`include "ucr_defines.svh"

module ucr_serial_ctrl
    import ucr_pkg::*;
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    input wire logic rx_pin_i,
    output logic tx_pin_o,
    output logic tx_irq_o,
    output logic rx_irq_o,
    output logic err_irq_o
);

// ----------------------------------------------------------------
// register state
// ----------------------------------------------------------------
logic [7:0] ctrl_one_r;
logic [7:0] ctrl_two_r;
logic [3:0] err_en_r;
logic tx_ninth_r;
logic rx_ninth_r;
logic [7:0] status_r;
logic [7:0] tx_buf_r;
logic [7:0] rx_buf_r;
logic [15:0] baud_r;
logic [31:0] dat_r;
logic ack_r;

logic unit_on;
logic nine;
assign unit_on = ctrl_one_r[`UCR_C1_UNIT];
assign nine = ctrl_one_r[`UCR_C1_NINE];

logic acc;
logic wr;
logic rd;
assign acc = cyc_i & stb_i & ~ack_r;
assign wr = acc & we_i & sel_i[0];
assign rd = acc & ~we_i;

function automatic logic hit(input logic [7:0] a, input logic [7:0] ofs);
    hit = (a == ofs);
endfunction : hit

// ----------------------------------------------------------------
// wishbone slave: one wait state, unmapped reads give zero
// ----------------------------------------------------------------
always_ff @(posedge clk_i)
begin
    if (rst_i)
        ack_r <= 1'b0;
    else
        ack_r <= acc;
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
        dat_r <= 32'h0;
    else if (rd)
    begin
        dat_r <= 32'h0;
        if (hit(adr_i, `UCR_OFS_CTRL_ONE))
            dat_r[7:0] <= ctrl_one_r;
        else if (hit(adr_i, `UCR_OFS_CTRL_TWO))
            dat_r[7:0] <= ctrl_two_r;
        else if (hit(adr_i, `UCR_OFS_CTRL_THREE))
            dat_r[7:0] <= {rx_ninth_r, tx_ninth_r, 2'b00, err_en_r};
        else if (hit(adr_i, `UCR_OFS_STATUS_ONE))
            dat_r[7:0] <= status_r;
        else if (hit(adr_i, `UCR_OFS_DATA))
            dat_r[7:0] <= rx_buf_r;
        else if (hit(adr_i, `UCR_OFS_BAUD))
            dat_r[15:0] <= baud_r;
    end
end

assign ack_o = ack_r;
assign dat_o = dat_r;

// ----------------------------------------------------------------
// control registers
// ----------------------------------------------------------------
logic unit_off_ev;
assign unit_off_ev = wr & hit(adr_i, `UCR_OFS_CTRL_ONE)
    & unit_on & ~dat_i[`UCR_C1_UNIT];

always_ff @(posedge clk_i)
begin
    if (rst_i)
        ctrl_one_r <= 8'h00;
    else if (wr && hit(adr_i, `UCR_OFS_CTRL_ONE))
        ctrl_one_r <= dat_i[7:0];
end

logic wake_ev;

always_ff @(posedge clk_i)
begin
    if (rst_i)
        ctrl_two_r <= 8'h00;
    else
    begin
        if (wr && hit(adr_i, `UCR_OFS_CTRL_TWO))
        begin
            ctrl_two_r[7:4] <= dat_i[7:4];
            ctrl_two_r[1:0] <= dat_i[1:0];
            // enables refused while unit off [R13]
            if (unit_on)
                ctrl_two_r[3:2] <= dat_i[3:2];
        end
        if (wake_ev)
            ctrl_two_r[`UCR_C2_STBY] <= 1'b0; // [R15]
        if (unit_off_ev)
            ctrl_two_r[3:2] <= 2'b00;
    end
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
        err_en_r <= 4'h0;
    else if (wr && hit(adr_i, `UCR_OFS_CTRL_THREE))
        err_en_r <= dat_i[3:0];
end

// ninth bits are left alone by reset [R20]
always_ff @(posedge clk_i)
begin
    if (wr && hit(adr_i, `UCR_OFS_CTRL_THREE))
        tx_ninth_r <= dat_i[`UCR_C3_TX9];
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
        baud_r <= `UCR_BAUD_RESET;
    else if (wr && hit(adr_i, `UCR_OFS_BAUD))
        baud_r <= dat_i[15:0];
end

// ----------------------------------------------------------------
// baud generator: tick at sixteen times the bit rate
// ----------------------------------------------------------------
logic [15:0] bcnt_r;
logic tick;
assign tick = unit_on & (bcnt_r == 16'h0000);

always_ff @(posedge clk_i)
begin
    if (rst_i || !unit_on || bcnt_r == 16'h0000)
        bcnt_r <= baud_r; // [R03]
    else
        bcnt_r <= bcnt_r - 16'h0001;
end

logic [3:0] flen;
assign flen = nine ? 4'hb : 4'ha; // [R05]

// ----------------------------------------------------------------
// transmitter
// ----------------------------------------------------------------
ucr_tx_state_t tx_st_r;
logic [10:0] tx_sh_r;
logic [3:0] tx_left_r;
logic [3:0] tx_ph_r;
logic tx_line_r;
logic pre_q_r;
logic tail_q_r;
logic txon_d_r;
logic tx_pin_r;
logic tx_bit;
logic tx_load;
logic txon;
logic brk;
assign txon = ctrl_two_r[`UCR_C2_TXON];
assign brk = ctrl_two_r[`UCR_C2_BRK];
assign tx_bit = tick & (tx_ph_r == `UCR_OVERSAMPLE);

logic [7:0] lo8;
logic b8;
logic dpar;
always_comb
begin
    lo8 = tx_buf_r;
    dpar = nine ? (^tx_buf_r) : (^tx_buf_r[6:0]);
    dpar = dpar ^ ctrl_one_r[`UCR_C1_ODD];
    b8 = nine ? tx_ninth_r : 1'b1;
    if (ctrl_one_r[`UCR_C1_PON])
    begin
        if (nine)
            b8 = dpar; // [R06]
        else
            lo8[7] = dpar; // [R06]
    end
end

always_ff @(posedge clk_i)
begin
    if (rst_i || !unit_on)
        tx_ph_r <= 4'h0;
    else if (tick)
        tx_ph_r <= tx_ph_r + 4'h1;
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
        txon_d_r <= 1'b0;
    else
        txon_d_r <= txon;
end

// a rising enable queues a preamble; mid-frame it waits for the end
always_ff @(posedge clk_i)
begin
    if (rst_i || !unit_on)
        pre_q_r <= 1'b0;
    else if (txon && !txon_d_r)
        pre_q_r <= 1'b1; // [R10] [R12]
    else if (tx_bit && tx_left_r == 4'h0 && txon)
        pre_q_r <= 1'b0;
end

assign tx_load = tx_bit & (tx_left_r == 4'h0) & txon & ~pre_q_r
    & ~brk & ~tail_q_r & ~status_r[`UCR_S1_EMPTY];

always_ff @(posedge clk_i)
begin
    if (rst_i || !unit_on)
    begin
        tx_st_r <= UCR_TX_IDLE;
        tx_sh_r <= 11'h7ff;
        tx_left_r <= 4'h0;
        tx_line_r <= 1'b1;
        tail_q_r <= 1'b0;
    end
    else if (tx_bit)
    begin
        if (tx_st_r == UCR_TX_SHIFT && tx_left_r != 4'h0)
        begin
            tx_line_r <= tx_sh_r[0];
            tx_sh_r <= {1'b1, tx_sh_r[10:1]};
            tx_left_r <= tx_left_r - 4'h1;
        end
        else if (txon && pre_q_r)
        begin
            tx_st_r <= UCR_TX_SHIFT; // [R25]
            tx_sh_r <= 11'h7ff;
            tx_line_r <= 1'b1;
            tx_left_r <= flen - 4'h1;
        end
        else if (txon && brk)
        begin
            // breaks abut with no mark [R17]
            tx_st_r <= UCR_TX_SHIFT;
            tx_sh_r <= 11'h000;
            tx_line_r <= 1'b0;
            tx_left_r <= flen - 4'h1;
            tail_q_r <= 1'b1;
        end
        else if (tail_q_r)
        begin
            // one mark after a break so a start is seen
            tx_st_r <= UCR_TX_SHIFT; // [R16]
            tx_line_r <= 1'b1;
            tx_left_r <= 4'h0;
            tail_q_r <= 1'b0;
        end
        else if (tx_load)
        begin
            tx_st_r <= UCR_TX_SHIFT;
            tx_sh_r <= {2'b11, b8, lo8}; // [R20]
            tx_line_r <= 1'b0;
            tx_left_r <= flen - 4'h1;
        end
        else
        begin
            // idle: disabled transmitter only stops between frames [R11]
            tx_st_r <= UCR_TX_IDLE;
            tx_line_r <= 1'b1;
        end
    end
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
        tx_pin_r <= 1'b1;
    else
        tx_pin_r <= tx_line_r ^ ctrl_one_r[`UCR_C1_POL]; // [R04]
end

assign tx_pin_o = tx_pin_r;

always_ff @(posedge clk_i)
begin
    if (wr && hit(adr_i, `UCR_OFS_DATA))
        tx_buf_r <= dat_i[7:0];
end

// ----------------------------------------------------------------
// receiver
// ----------------------------------------------------------------
logic rx_s1_r;
logic rx_s2_r;
always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        rx_s1_r <= 1'b1;
        rx_s2_r <= 1'b1;
    end
    else
    begin
        rx_s1_r <= rx_pin_i;
        rx_s2_r <= rx_s1_r;
    end
end

logic rx_in;
assign rx_in = ctrl_one_r[`UCR_C1_LOOP] ? tx_line_r : rx_s2_r; // [R01]

ucr_rx_state_t rx_st_r;
logic [3:0] rx_ph_r;
logic [3:0] rx_left_r;
logic [9:0] rx_sh_r;
logic [2:0] smp_r;
logic noisy_r;
logic [7:0] ones_r;
logic idle_armed_r;
logic idle_done_r;
logic rx_on;
logic maj;
logic mid;
logic fr_done;
logic idle_ev;
assign rx_on = unit_on & ctrl_two_r[`UCR_C2_RXON];
assign mid = tick & (rx_ph_r == `UCR_MID_HI);
assign maj = (smp_r[0] & smp_r[1]) | (smp_r[1] & rx_in)
    | (smp_r[0] & rx_in);
assign fr_done = mid & (rx_st_r == UCR_RX_BITS) & (rx_left_r == 4'h0);

always_ff @(posedge clk_i)
begin
    if (rst_i || !rx_on)
    begin
        // flags survive a disable [R14]
        rx_st_r <= UCR_RX_IDLE;
        rx_ph_r <= 4'h0;
        rx_left_r <= 4'h0;
        smp_r <= 3'b111;
        noisy_r <= 1'b0;
    end
    else if (tick)
    begin
        rx_ph_r <= rx_ph_r + 4'h1;
        if (rx_ph_r >= `UCR_MID_LO)
            smp_r <= {smp_r[1:0], rx_in};
        case (rx_st_r)
            UCR_RX_IDLE:
            begin
                rx_ph_r <= 4'h1;
                noisy_r <= 1'b0;
                if (!rx_in)
                    rx_st_r <= UCR_RX_START;
            end
            UCR_RX_START:
            begin
                if (mid)
                begin
                    noisy_r <= (smp_r[1:0] != {2{rx_in}});
                    if (maj)
                        rx_st_r <= UCR_RX_IDLE;
                    else
                    begin
                        rx_st_r <= UCR_RX_BITS;
                        rx_left_r <= flen - 4'h2;
                    end
                end
            end
            UCR_RX_BITS:
            begin
                if (mid)
                begin
                    rx_sh_r <= {maj, rx_sh_r[9:1]};
                    if (smp_r[1:0] != {2{rx_in}})
                        noisy_r <= 1'b1;
                    if (rx_left_r == 4'h0)
                        rx_st_r <= UCR_RX_IDLE;
                    else
                        rx_left_r <= rx_left_r - 4'h1;
                end
            end
            default:
                rx_st_r <= UCR_RX_IDLE;
        endcase
    end
end

// the stop bit is maj at fr_done
logic [8:0] ch;
logic msb;
logic perr;
logic nz;
always_comb
begin
    ch = nine ? rx_sh_r[9:1] : {1'b0, rx_sh_r[9:2]};
    msb = nine ? ch[8] : ch[7];
    perr = ctrl_one_r[`UCR_C1_PON]
        & ((nine ? (^ch) : (^ch[7:0])) ^ ctrl_one_r[`UCR_C1_ODD]); // [R06]
    nz = noisy_r | (smp_r[1:0] != {2{rx_in}});
end

// idle counter in ticks of consecutive ones
always_ff @(posedge clk_i)
begin
    if (rst_i || !rx_on)
        ones_r <= 8'h00;
    else if (tick)
    begin
        if (!rx_in)
            ones_r <= 8'h00;
        else if (rx_st_r == UCR_RX_START)
            ones_r <= 8'h00;
        else if (rx_st_r == UCR_RX_BITS && ctrl_one_r[`UCR_C1_ICNT])
            ones_r <= 8'h00; // [R09]
        else if (ones_r != 8'hff)
            ones_r <= ones_r + 8'h01;
    end
end

assign idle_ev = tick & ~idle_done_r & (ones_r == {flen, 4'h0}); // [R09]

always_ff @(posedge clk_i)
begin
    if (rst_i || !rx_on)
        idle_done_r <= 1'b0;
    else if (idle_ev)
        idle_done_r <= 1'b1;
    else if (tick && !rx_in)
        idle_done_r <= 1'b0;
end

logic stby;
logic deliver;
assign stby = ctrl_two_r[`UCR_C2_STBY];
// in standby only an address mark delivers [R23]
assign deliver = fr_done & (~stby | (ctrl_one_r[`UCR_C1_MARK] & msb));
assign wake_ev = stby & (ctrl_one_r[`UCR_C1_MARK]
    ? (fr_done & msb) : idle_ev); // [R08] [R15]

always_ff @(posedge clk_i)
begin
    if (deliver && !status_r[`UCR_S1_FULL])
    begin
        rx_buf_r <= ch[7:0];
        rx_ninth_r <= nine ? ch[8] : ch[7]; // [R19]
    end
end

// ----------------------------------------------------------------
// status flags: low six write one to clear, a hardware set wins
// ----------------------------------------------------------------
logic [7:0] clr;
logic [7:0] set;
logic tx_quiet;
assign clr = (wr && hit(adr_i, `UCR_OFS_STATUS_ONE)) ? dat_i[7:0] : 8'h00;
assign tx_quiet = (tx_st_r == UCR_TX_IDLE) & ~pre_q_r & ~tail_q_r
    & ~(txon & brk);

always_comb
begin
    set = 8'h00;
    set[`UCR_S1_EMPTY] = tx_load; // [R24]
    set[`UCR_S1_FULL] = deliver; // [R23]
    // the idle that wakes the receiver is swallowed [R23]
    set[`UCR_S1_IDLE] = idle_ev & idle_armed_r & ~stby;
    set[`UCR_S1_OVR] = deliver & status_r[`UCR_S1_FULL];
    set[`UCR_S1_NOISE] = deliver & nz;
    set[`UCR_S1_FRAME] = deliver & ~maj;
    set[`UCR_S1_PAR] = deliver & perr;
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
        idle_armed_r <= 1'b0;
    else if (deliver)
        idle_armed_r <= 1'b1;
    else if (set[`UCR_S1_IDLE] || clr[`UCR_S1_IDLE])
        idle_armed_r <= 1'b0;
end

always_ff @(posedge clk_i)
begin
    if (rst_i)
        status_r <= 8'hc0; // [R24]
    else if (!unit_on)
    begin
        status_r[`UCR_S1_EMPTY] <= 1'b1; // [R03]
        status_r[`UCR_S1_DONE] <= 1'b1; // [R03]
        status_r[5:0] <= (status_r[5:0] & ~clr[5:0]) | set[5:0];
    end
    else
    begin
        if (tx_load)
            status_r[`UCR_S1_EMPTY] <= 1'b1; // [R24]
        else if (wr && hit(adr_i, `UCR_OFS_DATA))
            status_r[`UCR_S1_EMPTY] <= 1'b0;
        status_r[`UCR_S1_DONE] <= status_r[`UCR_S1_EMPTY] & tx_quiet
            & ~tx_load;
        status_r[5:0] <= (status_r[5:0] & ~clr[5:0]) | set[5:0];
    end
end

// ----------------------------------------------------------------
// interrupt request lines
// ----------------------------------------------------------------
always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        tx_irq_o <= 1'b0;
        rx_irq_o <= 1'b0;
        err_irq_o <= 1'b0;
    end
    else
    begin
        tx_irq_o <= unit_on & ( // [R03]
            (ctrl_two_r[`UCR_C2_TEIE] & status_r[`UCR_S1_EMPTY])
            | (ctrl_two_r[`UCR_C2_DNIE] & status_r[`UCR_S1_DONE])); // [R21]
        rx_irq_o <= ~stby & ( // [R15]
            (ctrl_two_r[`UCR_C2_RFIE] & status_r[`UCR_S1_FULL])
            | (ctrl_two_r[`UCR_C2_IDIE] & status_r[`UCR_S1_IDLE])); // [R21]
        err_irq_o <= |(err_en_r & status_r[3:0]); // [R22]
    end
end

endmodule : ucr_serial_ctrl

//--- ucr_serial_ctrl_asserts.sv
`timescale 1ns/1ns
`include "ucr_defines.svh"

module ucr_serial_ctrl_asserts
(
    input wire logic clk_i,
    input wire logic rst_i,
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [7:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    input wire logic [31:0] dat_o,
    input wire logic ack_o,
    input wire logic rx_pin_i,
    input wire logic tx_pin_o,
    input wire logic tx_irq_o,
    input wire logic rx_irq_o,
    input wire logic err_irq_o
);
// ----------------------------------------
// shadow of software writes
// ----------------------------------------
logic [7:0] c1_r, c2_r, c3_r;
logic [1:0] quiet_r;
logic wr_hit, req, rd_req, quiet, unit, pol;
assign wr_hit = cyc_i & stb_i & we_i & ack_o & sel_i[0];
assign req = cyc_i & stb_i & !ack_o;
assign rd_req = req & !we_i;
// registered outputs settle two cycles after a write
assign quiet = quiet_r[1];
assign unit = c1_r[`UCR_C1_UNIT];
assign pol = c1_r[`UCR_C1_POL];

always_ff @(posedge clk_i)
begin
    if (rst_i)
    begin
        c1_r <= 8'h00;
        c2_r <= 8'h00;
        c3_r <= 8'h00;
    end
    else if (wr_hit && adr_i == `UCR_OFS_CTRL_ONE)
        c1_r <= dat_i[7:0];
    else if (wr_hit && adr_i == `UCR_OFS_CTRL_TWO)
        c2_r <= dat_i[7:0];
    else if (wr_hit && adr_i == `UCR_OFS_CTRL_THREE)
        c3_r <= dat_i[7:0];
end

always_ff @(posedge clk_i)
begin
    if (rst_i || wr_hit)
        quiet_r <= 2'h0;
    else if (quiet_r != 2'h3)
        quiet_r <= quiet_r + 2'h1;
end

// ----------------------------------------
// properties
// ----------------------------------------
default clocking cb @(posedge clk_i); endclocking
default disable iff (rst_i);

AST_ACK_NEXT: assert property (req |=> ack_o)
    else $error("no answer one cycle after request");
AST_ACK_ONE: assert property (ack_o |=> !ack_o)
    else $error("ack longer than one cycle");
AST_IDLE_POL: assert property (quiet && !unit |-> tx_pin_o == !pol)
    else $error("idle level does not follow polarity");
AST_TXIRQ_OFF: assert property (quiet && !unit |-> !tx_irq_o)
    else $error("tx irq while unit off");
AST_TXIRQ_EN: assert property (quiet && c2_r[7:6] == 2'h0 |-> !tx_irq_o)
    else $error("tx irq without enable");
AST_RXIRQ_EN: assert property (quiet && c2_r[5:4] == 2'h0 |-> !rx_irq_o)
    else $error("rx irq without enable");
AST_ERRIRQ_EN: assert property (quiet && c3_r[3:0] == 4'h0 |-> !err_irq_o)
    else $error("error irq without enable");
AST_RD_C1: assert property (rd_req && adr_i == `UCR_OFS_CTRL_ONE
    |=> dat_o == {24'h0, c1_r})
    else $error("ctrl_one readback wrong");
AST_RD_C2: assert property (rd_req && adr_i == `UCR_OFS_CTRL_TWO
    |=> dat_o[7:4] == c2_r[7:4])
    else $error("ctrl_two enables readback wrong");
AST_RD_C3: assert property (rd_req && adr_i == `UCR_OFS_CTRL_THREE
    |=> dat_o[3:0] == c3_r[3:0])
    else $error("ctrl_three enables readback wrong");

CV_BRK: cover property (wr_hit && adr_i == `UCR_OFS_CTRL_TWO && dat_i[0]);
CV_TXFALL: cover property ($fell(tx_pin_o));
CV_RXIRQ: cover property (rx_irq_o);
endmodule : ucr_serial_ctrl_asserts

bind ucr_serial_ctrl ucr_serial_ctrl_asserts u_chk (
    .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
    .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
    .dat_o(dat_o), .ack_o(ack_o), .rx_pin_i(rx_pin_i),
    .tx_pin_o(tx_pin_o), .tx_irq_o(tx_irq_o), .rx_irq_o(rx_irq_o),
    .err_irq_o(err_irq_o));
